// >>> rtl/scn_tap_ctrl.sv
// Test access port controller with instruction and chain select registers.
// Assumes tck_i is far slower than ref_clk_i and chain_tdo_i is local.
// Contract
// RULE1 - Up to 32 chains are addressed by number; 0 to 15 belong to the core.
// RULE2 - Chains 0,1,2,4,5,15 are internal; chain 3 is the optional boundary chain.
// RULE3 - Chains 16-31 may be external; a 5-bit output names the chain accessed.
// RULE4 - Current TAP state number is shown on a 4-bit output.
// RULE5 - Test reset low resets the port with no test clock edges needed.
// RULE6 - On test reset all boundary cells go to system mode.
// RULE7 - On test reset the identification instruction becomes current.
// RULE8 - Instruction register is 4 bits, no parity, captures 0001.
// RULE9 - Instruction codes decode to the ten listed functions.
// RULE10 - Far side never issues EXTEST, HIGHZ or clamp disable on chains 0-15.
// RULE11 - TDI and TMS sampled on test clock rise; TDO changes after its fall.
// RULE12 - EXTEST puts selected chain in test mode; shifted data drives system.
// RULE13 - Chain select puts a 5-bit register on the path, capturing 10000.
// RULE14 - Update-DR under chain select makes the shifted chain the path.
// RULE15 - After test reset chain 3 is selected.
// RULE16 - INTEST puts selected chain in test mode and captures core outputs.
// RULE17 - IDCODE puts the 32-bit identification register on the path.
// RULE18 - IDCODE captures the code, shifts it out, ignores Update-DR.
// RULE19 - Undefined codes act as BYPASS: one bit, captures 0, no update.
// RULE20 - Restart acts as BYPASS and leaves debug on entering Run-Test/Idle.
// RULE21 - Identification capture loads 32 bits from a dedicated input bus.
// RULE22 - Standard sixteen-state TAP, TMS-driven, async reset on test reset.
module scn_tap_ctrl
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic test_reset_n_i,
    input wire logic tck_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    input wire logic [scn_pkg::ID_W-1:0] id_code_input_bus_i,
    input wire logic chain_tdo_i,
    input wire logic chain_ready_i,
    output scn_pkg::scn_op_s chain_op_o,
    output logic chain_valid_o,
    output logic tdo_o,
    output logic tdo_oe_n_o,
    output logic [3:0] tap_state_output_o,
    output logic [scn_pkg::CSEL_W-1:0] external_chain_number_o,
    output logic chain_internal_o,
    output logic scan_test_mode_o,
    output logic clamp_o,
    output logic highz_o,
    output logic clamp_disable_instruction_o,
    output logic restart_o
);
    import scn_pkg::*;

    function automatic scn_state_e next_state(input scn_state_e s, input logic tms);
        case (s)
            ST_TLR: next_state = tms ? ST_TLR : ST_RTI;
            ST_RTI: next_state = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: next_state = tms ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: next_state = tms ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: next_state = tms ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_RTI;
            default: next_state = ST_TLR;
        endcase
    endfunction

    function automatic logic [3:0] state_num(input scn_state_e s);
        case (s)
            ST_TLR: state_num = SN_TLR;
            ST_RTI: state_num = SN_RTI;
            ST_SEL_DR: state_num = SN_SEL_DR;
            ST_CAP_DR: state_num = SN_CAP_DR;
            ST_SH_DR: state_num = SN_SH_DR;
            ST_EX1_DR: state_num = SN_EX1_DR;
            ST_PA_DR: state_num = SN_PA_DR;
            ST_EX2_DR: state_num = SN_EX2_DR;
            ST_UPD_DR: state_num = SN_UPD_DR;
            ST_SEL_IR: state_num = SN_SEL_IR;
            ST_CAP_IR: state_num = SN_CAP_IR;
            ST_SH_IR: state_num = SN_SH_IR;
            ST_EX1_IR: state_num = SN_EX1_IR;
            ST_PA_IR: state_num = SN_PA_IR;
            ST_EX2_IR: state_num = SN_EX2_IR;
            ST_UPD_IR: state_num = SN_UPD_IR;
            default: state_num = SN_TLR;
        endcase
    endfunction

    // Unlisted codes fold into bypass
    function automatic logic [3:0] decode(input logic [3:0] ir);
        case (ir)
            INS_EXTEST, INS_SCAN_SEL, INS_SAMPLE, INS_RESTART, INS_CLAMP,
            INS_HIGHZ, INS_CLAMP_DIS, INS_INTEST, INS_IDCODE: decode = ir; // [RULE9]
            default: decode = INS_BYPASS; // [RULE19]
        endcase
    endfunction

    // Test reset acts without the test clock; pin is used as a reset only
    logic tap_rst_n;
    assign tap_rst_n = nrst_i & test_reset_n_i; // [RULE5] [RULE22]

    logic [SYNC_W-1:0] pins_lvl;
    logic tck_s;
    logic tms_s;
    logic tdi_s;
    logic tck_prev_q;
    logic rise_pend_q;
    logic fall_pend_q;
    logic tms_q;
    logic tdi_q;
    logic take;
    logic fall_take;
    logic push_want;
    logic buf_ready;
    scn_op_s push_op;

    scn_state_e state_q;
    scn_state_e state_nx;
    logic [IR_W-1:0] ir_sr_q;
    logic [IR_W-1:0] ir_q;
    logic [3:0] code;
    logic [ID_W-1:0] dr_sr_q;
    logic [CSEL_W-1:0] chain_sel_q;
    logic chain_path;
    logic tdo_q;
    logic tdo_oe_n_q;
    logic restart_q;
    logic [3:0] state_out_q;
    logic test_mode_q;
    logic clamp_q;
    logic highz_q;
    logic clamp_dis_q;

    scn_sync3 u_sync
    (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .pin_i({tdi_i, tms_i, tck_i}),
        .level_o(pins_lvl)
    );
    assign tck_s = pins_lvl[0];
    assign tms_s = pins_lvl[1];
    assign tdi_s = pins_lvl[2];

    assign code = decode(ir_q);
    assign chain_path = (code == INS_EXTEST) || (code == INS_INTEST) || (code == INS_SAMPLE); // [RULE12] [RULE16]
    assign push_want = rise_pend_q && chain_path && (state_q inside {ST_CAP_DR, ST_SH_DR, ST_UPD_DR});
    // A full buffer holds the edge pending, so no chain step is lost
    assign take = rise_pend_q && (!push_want || buf_ready);
    assign fall_take = fall_pend_q && !rise_pend_q;
    assign state_nx = next_state(state_q, tms_q);

    // Edge finding; the rise captures TMS and TDI
    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            tck_prev_q <= 1'b0;
            rise_pend_q <= 1'b0;
            fall_pend_q <= 1'b0;
            tms_q <= 1'b1;
            tdi_q <= 1'b0;
        end
        else
        begin
            tck_prev_q <= tck_s;
            if (tck_s && !tck_prev_q)
            begin
                rise_pend_q <= 1'b1;
                tms_q <= tms_s; // [RULE11]
                tdi_q <= tdi_s; // [RULE11]
            end
            else if (take)
            begin
                rise_pend_q <= 1'b0;
            end
            if (!tck_s && tck_prev_q)
            begin
                fall_pend_q <= 1'b1;
            end
            else if (fall_take)
            begin
                fall_pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            state_q <= ST_TLR; // [RULE22]
        end
        else if (take)
        begin
            state_q <= state_nx; // [RULE22]
        end
    end

    // Instruction register, LSB first
    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            ir_sr_q <= IR_CAPTURE;
            ir_q <= INS_IDCODE; // [RULE7]
        end
        else if (state_q == ST_TLR)
        begin
            ir_q <= INS_IDCODE; // [RULE7]
        end
        else if (take)
        begin
            case (state_q)
                ST_CAP_IR: ir_sr_q <= IR_CAPTURE; // [RULE8]
                ST_SH_IR: ir_sr_q <= {tdi_q, ir_sr_q[IR_W-1:1]}; // [RULE8]
                ST_UPD_IR: ir_q <= ir_sr_q;
                default: ir_sr_q <= ir_sr_q;
            endcase
        end
    end

    // One shared data shift register; length set by the instruction
    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            dr_sr_q <= '0;
        end
        else if (take && state_q == ST_CAP_DR)
        begin
            case (code)
                INS_IDCODE: dr_sr_q <= id_code_input_bus_i; // [RULE17] [RULE18] [RULE21]
                INS_SCAN_SEL: dr_sr_q <= {27'h0, CSEL_CAPTURE}; // [RULE13]
                default: dr_sr_q <= '0; // [RULE19] [RULE20]
            endcase
        end
        else if (take && state_q == ST_SH_DR)
        begin
            case (code)
                INS_IDCODE: dr_sr_q <= {tdi_q, dr_sr_q[ID_W-1:1]}; // [RULE18]
                INS_SCAN_SEL: dr_sr_q <= {27'h0, tdi_q, dr_sr_q[CSEL_W-1:1]}; // [RULE13]
                default: dr_sr_q <= {31'h0, tdi_q}; // [RULE19]
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            chain_sel_q <= CSEL_RESET; // [RULE15]
        end
        else if (take && state_q == ST_UPD_DR && code == INS_SCAN_SEL)
        begin
            chain_sel_q <= dr_sr_q[CSEL_W-1:0]; // [RULE14] [RULE1]
        end
    end

    // Chain steps leave through the buffer; EXTEST data waits there until the chain takes it
    always_comb
    begin
        push_op.chain = chain_sel_q;
        push_op.tdi = tdi_q;
        case (state_q)
            ST_CAP_DR: push_op.op = OP_CAPTURE; // [RULE12] [RULE16]
            ST_UPD_DR: push_op.op = OP_UPDATE;
            default: push_op.op = OP_SHIFT; // [RULE12]
        endcase
    end

    scn_buf2 u_buf
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(tap_rst_n),
        .in_i(push_op),
        .in_valid_i(push_want && buf_ready),
        .in_ready_o(buf_ready),
        .out_o(chain_op_o),
        .out_valid_o(chain_valid_o),
        .out_ready_i(chain_ready_i)
    );

    // TDO moves only on the falling edge
    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            tdo_q <= 1'b0;
            tdo_oe_n_q <= 1'b1;
        end
        else if (fall_take)
        begin
            tdo_oe_n_q <= !(state_q == ST_SH_IR || state_q == ST_SH_DR); // [RULE11]
            if (state_q == ST_SH_IR)
            begin
                tdo_q <= ir_sr_q[0]; // [RULE11]
            end
            else if (state_q == ST_SH_DR)
            begin
                tdo_q <= chain_path ? chain_tdo_i : dr_sr_q[0]; // [RULE11] [RULE18]
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            restart_q <= 1'b0;
        end
        else
        begin
            restart_q <= take && state_nx == ST_RTI && state_q != ST_RTI && code == INS_RESTART; // [RULE20]
        end
    end

    always_ff @(posedge ref_clk_i or negedge tap_rst_n)
    begin
        if (!tap_rst_n)
        begin
            state_out_q <= SN_TLR;
            test_mode_q <= 1'b0; // [RULE6]
            clamp_q <= 1'b0;
            highz_q <= 1'b0;
            clamp_dis_q <= 1'b0;
        end
        else
        begin
            state_out_q <= state_num(state_q); // [RULE4]
            test_mode_q <= (code == INS_EXTEST) || (code == INS_INTEST); // [RULE6] [RULE12] [RULE16]
            clamp_q <= (code == INS_CLAMP);
            highz_q <= (code == INS_HIGHZ) && (chain_sel_q == CHAIN_CORE0);
            clamp_dis_q <= (code == INS_CLAMP_DIS) && (chain_sel_q == CHAIN_CORE0);
        end
    end

    assign tdo_o = tdo_q;
    assign tdo_oe_n_o = tdo_oe_n_q;
    assign tap_state_output_o = state_out_q;
    assign external_chain_number_o = chain_sel_q; // [RULE3]
    assign chain_internal_o = CHAIN_INTERNAL_MAP[chain_sel_q]; // [RULE2] [RULE1]
    assign scan_test_mode_o = test_mode_q;
    assign clamp_o = clamp_q;
    assign highz_o = highz_q;
    assign clamp_disable_instruction_o = clamp_dis_q;
    assign restart_o = restart_q;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!tap_rst_n);

    property p_ir_capture;
        take && state_q == ST_CAP_IR |=> ir_sr_q == IR_CAPTURE;
    endproperty
    a_ir_capture: assert property (p_ir_capture) else $error("IR capture not 0001"); // [RULE8]

    property p_csel_capture;
        take && state_q == ST_CAP_DR && code == INS_SCAN_SEL |=> dr_sr_q[CSEL_W-1:0] == CSEL_CAPTURE;
    endproperty
    a_csel_capture: assert property (p_csel_capture) else $error("Chain select capture wrong"); // [RULE13]

    property p_csel_update;
        take && state_q == ST_UPD_DR && code == INS_SCAN_SEL |=> chain_sel_q == $past(dr_sr_q[CSEL_W-1:0]);
    endproperty
    a_csel_update: assert property (p_csel_update) else $error("Chain select not updated"); // [RULE14]

    property p_id_capture;
        take && state_q == ST_CAP_DR && code == INS_IDCODE |=> dr_sr_q == $past(id_code_input_bus_i);
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("ID capture wrong"); // [RULE21]

    property p_bypass_capture;
        take && state_q == ST_CAP_DR && code == INS_BYPASS |=> dr_sr_q[0] == 1'b0;
    endproperty
    a_bypass_capture: assert property (p_bypass_capture) else $error("Bypass capture not zero"); // [RULE19]

    property p_state_out;
        $changed(state_q) |=> tap_state_output_o == state_num($past(state_q));
    endproperty
    a_state_out: assert property (p_state_out) else $error("State output lags"); // [RULE4]

    property p_sel_ir_reset;
        take && tms_q && state_q == ST_SEL_IR |=> state_q == ST_TLR ##1 ir_q == INS_IDCODE;
    endproperty
    a_sel_ir_reset: assert property (p_sel_ir_reset) else $error("TMS high path misses reset"); // [RULE22]

    sequence s_dr_fall;
        fall_take && state_q == ST_SH_DR && !chain_path;
    endsequence
    property p_tdo_fall;
        s_dr_fall |=> tdo_q == $past(dr_sr_q[0]) && !tdo_oe_n_o;
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("TDO not driven on fall"); // [RULE11]

    sequence s_restart_enter;
        take && state_nx == ST_RTI && state_q != ST_RTI && code == INS_RESTART;
    endsequence
    property p_restart;
        s_restart_enter |=> restart_o ##1 !restart_o;
    endproperty
    a_restart: assert property (p_restart) else $error("Restart pulse wrong"); // [RULE20]

    property p_stall;
        push_want && !buf_ready |=> $stable(state_q) && rise_pend_q;
    endproperty
    a_stall: assert property (p_stall) else $error("Edge taken while buffer full"); // [RULE12]
endmodule

// >>> include/scn_pkg.sv
// Package for the test access port and scan chain selector.
// Assumes one system clock that oversamples the serial test clock.
package scn_pkg;
    localparam int IR_W = 4;
    localparam int CSEL_W = 5;
    localparam int ID_W = 32;
    localparam int SYNC_W = 3;

    localparam logic [3:0] INS_EXTEST = 4'h0;
    localparam logic [3:0] INS_SCAN_SEL = 4'h2;
    localparam logic [3:0] INS_SAMPLE = 4'h3;
    localparam logic [3:0] INS_RESTART = 4'h4;
    localparam logic [3:0] INS_CLAMP = 4'h5;
    localparam logic [3:0] INS_HIGHZ = 4'h7;
    localparam logic [3:0] INS_CLAMP_DIS = 4'h9;
    localparam logic [3:0] INS_INTEST = 4'hC;
    localparam logic [3:0] INS_IDCODE = 4'hE;
    localparam logic [3:0] INS_BYPASS = 4'hF;

    localparam logic [3:0] IR_CAPTURE = 4'h1;
    localparam logic [4:0] CSEL_CAPTURE = 5'h10;
    localparam logic [4:0] CSEL_RESET = 5'h03;
    localparam logic [4:0] CHAIN_CORE0 = 5'h00;
    localparam logic [4:0] CHAIN_FIRST_EXT = 5'h10;
    // Chains wired inside the core; the rest are boundary or external
    localparam logic [31:0] CHAIN_INTERNAL_MAP = 32'h0000_8037;

    // Sync reset values: tck, tms, tdi
    localparam logic [2:0] SYNC_RST = 3'h2;

    localparam logic [3:0] SN_TLR = 4'hF;
    localparam logic [3:0] SN_RTI = 4'hC;
    localparam logic [3:0] SN_SEL_DR = 4'h7;
    localparam logic [3:0] SN_CAP_DR = 4'h6;
    localparam logic [3:0] SN_SH_DR = 4'h2;
    localparam logic [3:0] SN_EX1_DR = 4'h1;
    localparam logic [3:0] SN_PA_DR = 4'h3;
    localparam logic [3:0] SN_EX2_DR = 4'h0;
    localparam logic [3:0] SN_UPD_DR = 4'h5;
    localparam logic [3:0] SN_SEL_IR = 4'h4;
    localparam logic [3:0] SN_CAP_IR = 4'hE;
    localparam logic [3:0] SN_SH_IR = 4'hA;
    localparam logic [3:0] SN_EX1_IR = 4'h9;
    localparam logic [3:0] SN_PA_IR = 4'hB;
    localparam logic [3:0] SN_EX2_IR = 4'h8;
    localparam logic [3:0] SN_UPD_IR = 4'hD;

    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } scn_state_e;

    typedef enum logic [1:0] {
        OP_CAPTURE = 2'h0,
        OP_SHIFT = 2'h1,
        OP_UPDATE = 2'h2
    } scn_op_e;

    // One step sent to the selected chain
    typedef struct packed {
        logic [4:0] chain;
        scn_op_e op;
        logic tdi;
    } scn_op_s;
endpackage

// >>> rtl/scn_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Inputs are asynchronous pins; output is in the ref_clk_i domain.
module scn_sync3
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic [scn_pkg::SYNC_W-1:0] pin_i,
    output logic [scn_pkg::SYNC_W-1:0] level_o
);
    import scn_pkg::*;

    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++)
        begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            logic lvl_q;
            always_ff @(posedge ref_clk_i or negedge nrst_i)
            begin
                if (!nrst_i)
                begin
                    s1_q <= SYNC_RST[g];
                    s2_q <= SYNC_RST[g];
                    s3_q <= SYNC_RST[g];
                    lvl_q <= SYNC_RST[g];
                end
                else
                begin
                    s1_q <= pin_i[g];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    // Change counts only once stages two and three agree
                    if (s2_q == s3_q)
                    begin
                        lvl_q <= s3_q;
                    end
                end
            end
            assign level_o[g] = lvl_q;
        end
    endgenerate
endmodule

// >>> rtl/scn_buf2.sv
// Two-entry buffer for chain steps, valid/ready on both sides.
// Assumes the sink holds ready as it likes; full stalls the TAP.
module scn_buf2
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire scn_pkg::scn_op_s in_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output scn_pkg::scn_op_s out_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    import scn_pkg::*;

    scn_op_s mem_q [2];
    logic wr_q;
    logic rd_q;
    logic [1:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign out_o = mem_q[rd_q];

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= ~wr_q;
            end
            if (pop)
            begin
                rd_q <= ~rd_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    always_ff @(posedge ref_clk_i)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_i;
        end
    end
endmodule

// >>> tb/scn_jtag_host.sv
// Model of the external test controller that drives the serial pins.
// Assumes the bench calls step once per test clock period.
module scn_jtag_host
(
    input wire logic ref_clk_i,
    input wire logic tdo_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b1;
    end
    // Clock stands low between calls
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge ref_clk_i);
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (7) @(posedge ref_clk_i);
        tdo = tdo_i;
        tck_o <= 1'b1;
        repeat (8) @(posedge ref_clk_i);
        tck_o <= 1'b0;
        // Data not held past the fall, so show the inverse
        tdi_o <= ~tdi;
    endtask
endmodule

// >>> tb/test_scn_tap_ctrl.sv
// Bench for the test access port: reset, register paths, modes, chain buffer.
// Assumes scn_pkg is compiled first; test clock is 160 ns from the host model.
module test_scn_tap_ctrl;
    timeunit 1ns;
    timeprecision 100ps;
    import scn_pkg::*;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic test_reset_n_i = 1'b0;
    logic tck, tms, tdi, tdo, tdo_oe_n, chain_valid, internal, test_mode, clamp, highz, clamp_dis, restart;
    logic chain_ready_i = 1'b1;
    logic restart_seen = 1'b0;
    // Arbitrary identification value
    logic [31:0] id_bus = 32'h1234_5679;
    logic [31:0] o;
    logic [3:0] state;
    logic [4:0] chain;
    scn_op_s op;
    int mismatches = 0;
    int comparisons = 0;
    initial
    begin
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    always @(posedge ref_clk_i)
    begin
        if (restart === 1'b1)
            restart_seen <= 1'b1;
    end
    scn_jtag_host scn_jtag_host_inst (.ref_clk_i(ref_clk_i), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi));
    scn_tap_ctrl scn_tap_ctrl_inst (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .test_reset_n_i(test_reset_n_i),
        .tck_i(tck), .tms_i(tms), .tdi_i(tdi), .id_code_input_bus_i(id_bus), .chain_tdo_i(1'b0),
        .chain_ready_i(chain_ready_i), .chain_op_o(op), .chain_valid_o(chain_valid), .tdo_o(tdo),
        .tdo_oe_n_o(tdo_oe_n), .tap_state_output_o(state), .external_chain_number_o(chain),
        .chain_internal_o(internal), .scan_test_mode_o(test_mode), .clamp_o(clamp), .highz_o(highz),
        .clamp_disable_instruction_o(clamp_dis), .restart_o(restart));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (mismatches == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic walk(input logic [7:0] bits, input int n);
        logic b;
        for (int i = 0; i < n; i++)
            scn_jtag_host_inst.step(bits[i], 1'b0, b);
    endtask
    // Shifts LSB first; last bit leaves with TMS high, then Update and Run-Test/Idle
    task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic b;
        dout = '0;
        for (int i = 0; i < n; i++)
        begin
            scn_jtag_host_inst.step(i == n - 1, din[i], b);
            dout[i] = b;
        end
        walk(8'h01, 2);
    endtask
    task automatic ir(input logic [3:0] code);
        walk(8'h03, 4);
        shift(4, {28'h0, code}, o);
        chk(o, {28'h0, IR_CAPTURE});
    endtask
    task automatic dr(input int n, input logic [31:0] din);
        walk(8'h01, 3);
        shift(n, din, o);
    endtask
    task automatic s_reset();
        chk(tdo_oe_n, 1'b1);
        chk(state, 4'hF);
        chk(chain, CSEL_RESET);
        chk(test_mode, 1'b0);
        walk(8'h00, 1);
        repeat (4) @(posedge ref_clk_i);
        chk(state, SN_RTI);
        dr(32, 32'hFFFF_FFFF);
        chk(o, id_bus);
        dr(32, 32'h0);
        chk(o, id_bus);
    endtask
    task automatic s_chain();
        ir(INS_SCAN_SEL);
        dr(5, 32'h13);
        chk(o, {27'h0, CSEL_CAPTURE});
        chk(chain, 5'h13);
        chk(internal, 1'b0);
    endtask
    task automatic s_modes();
        logic [3:0] codes [6] = '{INS_EXTEST, INS_INTEST, INS_SAMPLE, INS_CLAMP, INS_HIGHZ, INS_CLAMP_DIS};
        // Chain 19 is selected, so test modes avoid the reserved chains
        for (int i = 0; i < 6; i++)
        begin
            ir(codes[i]);
            chk(test_mode, i < 2);
            chk(clamp, i == 3);
            chk(highz, 1'b0);
            chk(clamp_dis, 1'b0);
        end
    endtask
    task automatic s_bypass();
        logic [3:0] codes [3] = '{4'h6, INS_BYPASS, INS_RESTART};
        for (int i = 0; i < 3; i++)
        begin
            ir(codes[i]);
            dr(3, 32'h5);
            chk(o, 32'h2);
            chk(restart_seen, i == 2);
        end
        chk(restart_seen, 1'b1);
    endtask
    task automatic s_buffer();
        logic b;
        ir(INS_EXTEST);
        chain_ready_i <= 1'b0;
        // Fifth rise finds the buffer full and must wait
        walk(8'h01, 5);
        chk(state, SN_SH_DR);
        chk(chain_valid, 1'b1);
        chk(op.op, OP_CAPTURE);
        chk(op.chain, 5'h13);
        chain_ready_i <= 1'b1;
        scn_jtag_host_inst.step(1'b1, 1'b1, b);
        walk(8'h01, 2);
        repeat (4) @(posedge ref_clk_i);
        chk(chain_valid, 1'b0);
    endtask
    task automatic s_treset();
        walk(8'h1F, 5);
        repeat (4) @(posedge ref_clk_i);
        chk(state, SN_TLR);
        walk(8'h00, 1);
        test_reset_n_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        chk(state, SN_TLR);
        chk(chain, CSEL_RESET);
        chk(test_mode, 1'b0);
        test_reset_n_i <= 1'b1;
        walk(8'h00, 1);
        dr(32, 32'h0);
        chk(o, id_bus);
        ir(INS_SCAN_SEL);
        dr(5, 32'h0);
        chk(o, {27'h0, CSEL_CAPTURE});
        chk(chain, 5'h00);
        chk(internal, 1'b1);
    endtask
    initial
    begin
        repeat (12) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        test_reset_n_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        s_reset();
        s_chain();
        s_modes();
        s_bypass();
        s_buffer();
        s_treset();
        wrap_up();
    end
    initial
    begin
        #200_000;
        mismatches++;
        wrap_up();
    end
endmodule
